// ==== rtl/pcfg_pkg.sv ====
// Purpose: Shared constants for the capability constant bank
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   Configuration space addresses are dword indices
package pcfg_pkg;

    // Register bus
    localparam int unsigned AXI_AW      = 8;
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_PTR     = 8'h04;
    localparam logic [7:0]  OFS_DEVCAP  = 8'h08;
    localparam logic [7:0]  OFS_DEVCAP2 = 8'h0c;
    localparam logic [7:0]  OFS_LNKCAP  = 8'h10;
    localparam logic [7:0]  OFS_DSN_LO  = 8'h14;
    localparam logic [7:0]  OFS_DSN_HI  = 8'h18;
    localparam logic [7:0]  OFS_STAT    = 8'h1c;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Control word fields
    localparam int unsigned CTL_TERM    = 0;
    localparam int unsigned CTL_RO      = 1;
    localparam int unsigned CTL_MPS_LSB = 2;
    localparam int unsigned MPS_W       = 3;
    localparam int unsigned CTL_LW_LSB  = 5;
    localparam int unsigned LW_W        = 6;
    localparam int unsigned CTL_AER     = 11;
    localparam int unsigned CTL_V2      = 12;

    // Pointer word fields
    localparam int unsigned PTR_NXT_LSB = 0;
    localparam int unsigned NXT_W       = 8;
    localparam int unsigned PTR_EXT_LSB = 8;
    localparam int unsigned EXT_W       = 12;

    // Field widths of the constant words
    localparam int unsigned DEVCAP_W    = 25;
    localparam int unsigned DEVCAP2_W   = 5;
    localparam int unsigned LNKRSV_W    = 8;
    localparam int unsigned DSN_W       = 64;

    // Status word fields
    localparam int unsigned ST_CONFLICT = 0;
    localparam int unsigned ST_RB_LSB   = 1;
    localparam int unsigned ST_CPL_LSB  = 16;
    localparam int unsigned ST_USR_LSB  = 24;
    localparam int unsigned CNT_W       = 8;

    // Payload size codes: 0=128B ... 5=4KB
    localparam logic [2:0]  MPS_512B    = 3'h2;
    localparam logic [2:0]  MPS_MAX     = 3'h5;

    // Capability placement, dword indices and lengths; AER_BYTE in bytes
    localparam logic [9:0]  PCIE_DW     = 10'h018;
    localparam logic [9:0]  PCIE_LEN    = 10'h00a;
    localparam logic [9:0]  DSN_DW      = 10'h040;
    localparam logic [9:0]  DSN_LEN     = 10'h003;
    localparam logic [9:0]  AER_DW      = 10'h043;
    localparam logic [9:0]  AER_LEN     = 10'h00b;
    localparam logic [11:0] AER_BYTE    = 12'h10c;

    // Offsets inside structures
    localparam logic [9:0]  OF_DEVCAP   = 10'h001;
    localparam logic [9:0]  OF_DEVCTL   = 10'h002;
    localparam logic [9:0]  OF_LNKCAP   = 10'h003;
    localparam logic [9:0]  OF_DEVCAP2  = 10'h009;
    localparam logic [9:0]  OF_DSN_LO   = 10'h001;
    localparam logic [9:0]  OF_DSN_HI   = 10'h002;
    localparam logic [9:0]  OF_AER_UNC  = 10'h001;
    localparam logic [9:0]  OF_AER_COR  = 10'h004;
    localparam int unsigned DEVCTL_RO   = 4;

    // Identifiers and versions
    localparam logic [7:0]  CAPID_PCIE  = 8'h10;
    localparam logic [15:0] ECAP_DSN    = 16'h0003;
    localparam logic [15:0] ECAP_AER    = 16'h0001;
    localparam logic [3:0]  VER_PCIE_V2 = 4'h2;
    localparam logic [3:0]  VER_PCIE_V1 = 4'h1;
    localparam logic [3:0]  VER_DSN     = 4'h1;
    localparam logic [3:0]  VER_AER     = 4'h1;
    localparam logic [3:0]  LINK_SPEED  = 4'h1;

endpackage

// ==== rtl/pcfg_capmap.sv ====
// Purpose: Capability structure lookup by configuration dword index
// Assumes: All inputs on the same clock, pure combinational
// Notes:   Capability words are read only
`timescale 1ns/10ps
`default_nettype none
module pcfg_capmap (
    // Lookup
    input  wire logic [9:0]  dw,
    output logic             hit,
    output logic [31:0]      data,
    // Settings
    input  wire logic        v2,
    input  wire logic        ro_en,
    input  wire logic        aer_en,
    input  wire logic [2:0]  mps,
    input  wire logic [5:0]  link_w,
    input  wire logic [7:0]  next_ptr,
    input  wire logic [11:0] ext_ptr,
    input  wire logic [24:0] devcap,
    input  wire logic [4:0]  devcap2,
    input  wire logic [63:0] dsn,
    // Error state
    input  wire logic [31:0] aer_unc,
    input  wire logic [31:0] aer_cor
);

    function automatic logic in_rng(input logic [9:0] a, input logic [9:0] b,
                                    input logic [9:0] n);
        in_rng = (a >= b) && (a < 10'(b + n));
    endfunction

    wire        pcie_hit = in_rng(dw, pcfg_pkg::PCIE_DW, pcfg_pkg::PCIE_LEN);
    wire        dsn_hit  = in_rng(dw, pcfg_pkg::DSN_DW, pcfg_pkg::DSN_LEN);
    wire        aer_hit  = aer_en && in_rng(dw, pcfg_pkg::AER_DW, pcfg_pkg::AER_LEN);
    wire [9:0]  pcie_of  = dw - pcfg_pkg::PCIE_DW;
    wire [9:0]  dsn_of   = dw - pcfg_pkg::DSN_DW;
    wire [9:0]  aer_of   = dw - pcfg_pkg::AER_DW;
    wire [3:0]  pcie_ver = v2 ? pcfg_pkg::VER_PCIE_V2 : pcfg_pkg::VER_PCIE_V1;
    wire [11:0] dsn_next = aer_en ? pcfg_pkg::AER_BYTE : ext_ptr;

    // PCI Express structure words
    wire [31:0] pcie_d0 = {12'h000, pcie_ver, next_ptr, pcfg_pkg::CAPID_PCIE};
    wire [31:0] devcap_d = {4'h0, devcap, mps};
    wire [31:0] devctl_d = 32'(ro_en) << pcfg_pkg::DEVCTL_RO;
    wire [31:0] lnkcap_d = {14'h0000, 8'h00, link_w, pcfg_pkg::LINK_SPEED};
    wire [31:0] devcp2_d = {27'h0000000, devcap2};
    wire [31:0] pcie_d   = (pcie_of == 10'h000)             ? pcie_d0  :
                           (pcie_of == pcfg_pkg::OF_DEVCAP) ? devcap_d :
                           (pcie_of == pcfg_pkg::OF_DEVCTL) ? devctl_d :
                           (pcie_of == pcfg_pkg::OF_LNKCAP) ? lnkcap_d :
                           (pcie_of == pcfg_pkg::OF_DEVCAP2) ? devcp2_d : 32'h0;

    // Serial number structure words
    wire [31:0] dsn_d = (dsn_of == 10'h000) ? {dsn_next, pcfg_pkg::VER_DSN,
                                               pcfg_pkg::ECAP_DSN} :
                        (dsn_of == pcfg_pkg::OF_DSN_LO) ? dsn[31:0] :
                        (dsn_of == pcfg_pkg::OF_DSN_HI) ? dsn[63:32] : 32'h0;

    // Error reporting structure words
    wire [31:0] aer_d = (aer_of == 10'h000) ? {ext_ptr, pcfg_pkg::VER_AER,
                                               pcfg_pkg::ECAP_AER} :
                        (aer_of == pcfg_pkg::OF_AER_UNC) ? aer_unc :
                        (aer_of == pcfg_pkg::OF_AER_COR) ? aer_cor : 32'h0;

    assign hit  = pcie_hit || dsn_hit || aer_hit;
    assign data = pcie_hit ? pcie_d : dsn_hit ? dsn_d : aer_hit ? aer_d : 32'h0;

endmodule
`default_nettype wire

// ==== rtl/pcfg_top.sv ====
// Purpose: Capability constant bank with configuration request steering
// Assumes: Config requests arrive from link logic on aclk, one per pulse
// Notes:   Settings are software registers on AXI4-Lite
//
// What this block does
// - Next capability pointer resets to zero: no user standard capability.
// - Capability version reads 2 for revision 2.0, 1 for revision 1.1.
// - Payload size is advertised and sizes retry buffer, minimum 512B setting.
// - A 25-bit setting fills device capabilities bits 27 to 3.
// - Relaxed ordering setting changes only the advertised bit.
// - Configured maximum link width is advertised in link capabilities.
// - The 8-bit link capabilities 17 to 10 setting drives nothing.
// - A 5-bit setting fills device capabilities 2 bits 4 to 0.
// - Serial number capability reports version 1.
// - Serial number capability returns the configured 64-bit value.
// - Error reporting structure, when enabled, reports link and packet errors.
// - Error reporting capability reports version 1.
// - Terminate-all on: core completes every configuration request itself.
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module pcfg_top #(
    parameter logic        P_TERM     = 1'b1,
    parameter logic        P_RO       = 1'b1,
    parameter logic [2:0]  P_MPS      = 3'h0,
    parameter logic [5:0]  P_LINK_W   = 6'h01,
    parameter logic        P_AER      = 1'b1,
    parameter logic        P_V2       = 1'b1,
    parameter logic [7:0]  P_NEXT_PTR = 8'h00,
    parameter logic [11:0] P_EXT_PTR  = 12'h000,
    parameter logic [24:0] P_DEVCAP   = 25'h0000000,
    parameter logic [4:0]  P_DEVCAP2  = 5'h00,
    // Arbitrary serial number value
    parameter logic [63:0] P_DSN      = 64'h0123_4567_89ab_cdef
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Configuration request from link
    input  wire logic        cfg_req_valid,
    input  wire logic [9:0]  cfg_req_dw,
    input  wire logic        cfg_req_wr,
    input  wire logic [31:0] cfg_req_wdata,
    // Core completion
    output logic             cfg_cpl_valid,
    output logic [31:0]      cfg_cpl_data,
    // Request forwarded to user logic
    output logic             usr_req_valid,
    output logic [9:0]       usr_req_dw,
    output logic             usr_req_wr,
    output logic [31:0]      usr_req_wdata,
    // Error status from link logic
    input  wire logic [31:0] aer_unc_status,
    input  wire logic [31:0] aer_cor_status,
    // Settings to the link layer
    output logic [2:0]       retry_buf_size,
    output logic [5:0]       link_width_adv,
    output logic             cap_conflict
);

    // Byte lane merge
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        merge = r;
    endfunction

    // Word aligned offset
    function automatic logic [7:0] word_of(input logic [7:0] a);
        word_of = {a[7:2], 2'b00};
    endfunction

    // Settings and request counters
    logic        term_q;
    logic        ro_q;
    logic [2:0]  mps_q;
    logic [5:0]  lw_q;
    logic        aer_q;
    logic        v2_q;
    logic [7:0]  nxt_q;
    logic [11:0] ext_q;
    logic [24:0] devcap_q;
    logic [4:0]  devcap2_q;
    logic [7:0]  lnkrsv_q;
    logic [63:0] dsn_q;
    logic [7:0]  cpl_cnt_q;
    logic [7:0]  usr_cnt_q;

    // Bus state
    logic        aw_full_q;
    logic        w_full_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;

    // Write channel control
    wire        aw_fire   = s_axi_awvalid && s_axi_awready;
    wire        w_fire    = s_axi_wvalid && s_axi_wready;
    wire        do_write  = aw_full_q && w_full_q && !s_axi_bvalid;
    wire        bvalid_d  = do_write || (s_axi_bvalid && !s_axi_bready);
    wire        aw_full_d = aw_fire || (aw_full_q && !do_write);
    wire        w_full_d  = w_fire || (w_full_q && !do_write);
    wire [7:0]  wa        = word_of(aw_addr_q);

    // Write decode
    wire        wr_ctrl   = do_write && (wa == pcfg_pkg::OFS_CTRL);
    wire        wr_ptr    = do_write && (wa == pcfg_pkg::OFS_PTR);
    wire        wr_dcap   = do_write && (wa == pcfg_pkg::OFS_DEVCAP);
    wire        wr_dcap2  = do_write && (wa == pcfg_pkg::OFS_DEVCAP2);
    wire        wr_lnk    = do_write && (wa == pcfg_pkg::OFS_LNKCAP);
    wire        wr_dsnlo  = do_write && (wa == pcfg_pkg::OFS_DSN_LO);
    wire        wr_dsnhi  = do_write && (wa == pcfg_pkg::OFS_DSN_HI);
    wire        wr_mapped = wr_ctrl || wr_ptr || wr_dcap || wr_dcap2 || wr_lnk ||
                            wr_dsnlo || wr_dsnhi || (wa == pcfg_pkg::OFS_STAT);

    // Register images
    wire [31:0] ctrl_rd   = (32'(term_q) << pcfg_pkg::CTL_TERM) |
                            (32'(ro_q) << pcfg_pkg::CTL_RO) |
                            (32'(mps_q) << pcfg_pkg::CTL_MPS_LSB) |
                            (32'(lw_q) << pcfg_pkg::CTL_LW_LSB) |
                            (32'(aer_q) << pcfg_pkg::CTL_AER) |
                            (32'(v2_q) << pcfg_pkg::CTL_V2);
    wire [31:0] ptr_rd    = (32'(nxt_q) << pcfg_pkg::PTR_NXT_LSB) |
                            (32'(ext_q) << pcfg_pkg::PTR_EXT_LSB);
    wire [31:0] stat_rd   = (32'(cap_conflict) << pcfg_pkg::ST_CONFLICT) |
                            (32'(retry_buf_size) << pcfg_pkg::ST_RB_LSB) |
                            (32'(cpl_cnt_q) << pcfg_pkg::ST_CPL_LSB) |
                            (32'(usr_cnt_q) << pcfg_pkg::ST_USR_LSB);

    // New field values after byte merge
    wire [31:0] ctrl_m    = merge(ctrl_rd, w_data_q, w_strb_q);
    wire [31:0] ptr_m     = merge(ptr_rd, w_data_q, w_strb_q);
    wire [31:0] dcap_m    = merge(32'(devcap_q), w_data_q, w_strb_q);
    wire [31:0] dcap2_m   = merge(32'(devcap2_q), w_data_q, w_strb_q);
    wire [31:0] lnk_m     = merge(32'(lnkrsv_q), w_data_q, w_strb_q);
    wire [31:0] dsnlo_m   = merge(dsn_q[31:0], w_data_q, w_strb_q);
    wire [31:0] dsnhi_m   = merge(dsn_q[63:32], w_data_q, w_strb_q);
    wire [2:0]  mps_w     = ctrl_m[pcfg_pkg::CTL_MPS_LSB +: pcfg_pkg::MPS_W];
    wire [2:0]  mps_clamp = (mps_w > pcfg_pkg::MPS_MAX) ? pcfg_pkg::MPS_MAX : mps_w;

    // Read channel
    wire        ar_fire   = s_axi_arvalid && s_axi_arready;
    wire        rvalid_d  = ar_fire || (s_axi_rvalid && !s_axi_rready);
    wire [7:0]  ra        = word_of(s_axi_araddr);
    wire        rd_hit    = (ra <= pcfg_pkg::OFS_STAT);
    wire [31:0] rd_word   = (ra == pcfg_pkg::OFS_CTRL)    ? ctrl_rd :
                            (ra == pcfg_pkg::OFS_PTR)     ? ptr_rd :
                            (ra == pcfg_pkg::OFS_DEVCAP)  ? 32'(devcap_q) :
                            (ra == pcfg_pkg::OFS_DEVCAP2) ? 32'(devcap2_q) :
                            (ra == pcfg_pkg::OFS_LNKCAP)  ? 32'(lnkrsv_q) :
                            (ra == pcfg_pkg::OFS_DSN_LO)  ? dsn_q[31:0] :
                            (ra == pcfg_pkg::OFS_DSN_HI)  ? dsn_q[63:32] :
                            (ra == pcfg_pkg::OFS_STAT)    ? stat_rd : 32'h0;

    // Configuration request steering
    wire        cap_hit;
    wire [31:0] cap_data;
    wire        core_owns = term_q || cap_hit;
    wire        to_core   = cfg_req_valid && core_owns;
    wire        to_user   = cfg_req_valid && !core_owns;
    wire [31:0] cpl_d     = cfg_req_wr ? 32'h0 : cap_data;
    wire        conflict  = term_q && ((nxt_q != 8'h00) || (ext_q != 12'h000));
    wire [2:0]  rb_d      = (mps_q < pcfg_pkg::MPS_512B) ? pcfg_pkg::MPS_512B : mps_q;

    pcfg_capmap u_capmap (
        .dw       (cfg_req_dw),
        .hit      (cap_hit),
        .data     (cap_data),
        .v2       (v2_q),
        .ro_en    (ro_q),
        .aer_en   (aer_q),
        .mps      (mps_q),
        .link_w   (lw_q),
        .next_ptr (nxt_q),
        .ext_ptr  (ext_q),
        .devcap   (devcap_q),
        .devcap2  (devcap2_q),
        .dsn      (dsn_q),
        .aer_unc  (aer_unc_status),
        .aer_cor  (aer_cor_status)
    );

    // Bus handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q     <= 1'b0;
            w_full_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= pcfg_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= pcfg_pkg::RESP_OKAY;
        end else begin
            aw_full_q     <= aw_full_d;
            w_full_q      <= w_full_d;
            s_axi_awready <= !aw_full_d && !bvalid_d;
            s_axi_wready  <= !w_full_d && !bvalid_d;
            s_axi_bvalid  <= bvalid_d;
            s_axi_arready <= !rvalid_d;
            s_axi_rvalid  <= rvalid_d;
            if (aw_fire) begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bresp <= wr_mapped ? pcfg_pkg::RESP_OKAY : pcfg_pkg::RESP_SLVERR;
            end
            if (ar_fire) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? pcfg_pkg::RESP_OKAY : pcfg_pkg::RESP_SLVERR;
            end
        end
    end

    // Settings registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            term_q    <= P_TERM;
            ro_q      <= P_RO;
            mps_q     <= P_MPS;
            lw_q      <= P_LINK_W;
            aer_q     <= P_AER;
            v2_q      <= P_V2;
            nxt_q     <= P_NEXT_PTR;
            ext_q     <= P_EXT_PTR;
            devcap_q  <= P_DEVCAP;
            devcap2_q <= P_DEVCAP2;
            lnkrsv_q  <= 8'h00;
            dsn_q     <= P_DSN;
        end else begin
            if (wr_ctrl) begin
                term_q <= ctrl_m[pcfg_pkg::CTL_TERM];
                ro_q   <= ctrl_m[pcfg_pkg::CTL_RO];
                mps_q  <= mps_clamp;
                lw_q   <= ctrl_m[pcfg_pkg::CTL_LW_LSB +: pcfg_pkg::LW_W];
                aer_q  <= ctrl_m[pcfg_pkg::CTL_AER];
                v2_q   <= ctrl_m[pcfg_pkg::CTL_V2];
            end
            if (wr_ptr) begin
                nxt_q <= ptr_m[pcfg_pkg::PTR_NXT_LSB +: pcfg_pkg::NXT_W];
                ext_q <= ptr_m[pcfg_pkg::PTR_EXT_LSB +: pcfg_pkg::EXT_W];
            end
            if (wr_dcap) begin
                devcap_q <= dcap_m[pcfg_pkg::DEVCAP_W-1:0];
            end
            if (wr_dcap2) begin
                devcap2_q <= dcap2_m[pcfg_pkg::DEVCAP2_W-1:0];
            end
            if (wr_lnk) begin
                lnkrsv_q <= lnk_m[pcfg_pkg::LNKRSV_W-1:0];
            end
            if (wr_dsnlo) begin
                dsn_q[31:0] <= dsnlo_m;
            end
            if (wr_dsnhi) begin
                dsn_q[63:32] <= dsnhi_m;
            end
        end
    end

    // Request steering and status outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_cpl_valid  <= 1'b0;
            cfg_cpl_data   <= 32'h0;
            usr_req_valid  <= 1'b0;
            usr_req_dw     <= 10'h000;
            usr_req_wr     <= 1'b0;
            usr_req_wdata  <= 32'h0;
            cpl_cnt_q      <= 8'h00;
            usr_cnt_q      <= 8'h00;
            retry_buf_size <= pcfg_pkg::MPS_512B;
            link_width_adv <= 6'h00;
            cap_conflict   <= 1'b0;
        end else begin
            cfg_cpl_valid  <= to_core;
            usr_req_valid  <= to_user;
            retry_buf_size <= rb_d;
            link_width_adv <= lw_q;
            cap_conflict   <= conflict;
            if (to_core) begin
                cfg_cpl_data <= cpl_d;
                cpl_cnt_q    <= cpl_cnt_q + 8'h01;
            end
            if (to_user) begin
                usr_req_dw    <= cfg_req_dw;
                usr_req_wr    <= cfg_req_wr;
                usr_req_wdata <= cfg_req_wdata;
                usr_cnt_q     <= usr_cnt_q + 8'h01;
            end
        end
    end

endmodule
`default_nettype wire

// ==== test/pcfg_top_properties.sv ====
// Purpose: Port checks for pcfg_top
// Assumes: One clock domain, sync reset
// Notes: Bound after the module
`timescale 1ns/10ps
`default_nettype none
module pcfg_props (
    input wire logic aclk, aresetn, cfg_req_valid, cfg_req_wr, cfg_cpl_valid, usr_req_valid,
    input wire logic s_axi_bvalid, s_axi_bready, s_axi_rvalid, s_axi_rready,
    input wire logic [9:0] cfg_req_dw, usr_req_dw,
    input wire logic [31:0] cfg_cpl_data, s_axi_rdata,
    input wire logic [2:0] retry_buf_size
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic pcie_rq = cfg_req_valid && cfg_req_dw inside {[10'h018:10'h021]};
    wire logic dsn_rd = cfg_req_valid && !cfg_req_wr && cfg_req_dw == pcfg_pkg::DSN_DW;
    one_owner_a: assert property (cfg_req_valid |=> cfg_cpl_valid != usr_req_valid)
        else $error("not answered once");
    no_extra_a: assert property (!cfg_req_valid |=> !cfg_cpl_valid && !usr_req_valid)
        else $error("answer without request");
    fwd_dw_a: assert property (usr_req_valid |-> usr_req_dw == $past(cfg_req_dw))
        else $error("forwarded index wrong");
    core_own_a: assert property (pcie_rq |=> cfg_cpl_valid)
        else $error("core word forwarded");
    dsn_ver_a: assert property (dsn_rd |=> cfg_cpl_data[19:16] == 4'h1)
        else $error("serial version wrong");
    retry_min_a: assert property (retry_buf_size inside {[3'h2:3'h5]})
        else $error("retry size out of range");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    fwd_c: cover property (usr_req_valid);
    cpl_c: cover property (cfg_cpl_valid);
    wr_c: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind pcfg_top pcfg_props u_props (.aclk, .aresetn, .cfg_req_valid, .cfg_req_wr, .cfg_cpl_valid,
    .usr_req_valid, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .cfg_req_dw,
    .usr_req_dw, .cfg_cpl_data, .s_axi_rdata, .retry_buf_size);
`default_nettype wire

// ==== test/pcfg_rc_model.sv ====
// Purpose: Root complex issuing configuration requests
// Assumes: Called just after a rising edge
// Notes: Released lines show the inverse of their last value
`timescale 1ns/10ps
`default_nettype none
module pcfg_rc_model (
    input wire logic aclk,
    output logic cfg_req_valid = 1'b0,
    output logic cfg_req_wr = 1'b0,
    output logic [9:0] cfg_req_dw = 10'h0,
    output logic [31:0] cfg_req_wdata = 32'h0
);
    task automatic issue(input logic [9:0] dw, input logic wr);
        {cfg_req_valid, cfg_req_wr, cfg_req_dw, cfg_req_wdata} <= {1'b1, wr, dw, 22'h0, dw};
        @(posedge aclk);
        {cfg_req_valid, cfg_req_wr, cfg_req_dw, cfg_req_wdata} <= {1'b0, ~wr, ~dw, ~{22'h0, dw}};
    endtask
endmodule
`default_nettype wire

// ==== test/pcfg_top_bench.sv ====
// Purpose: Bench for pcfg_top
// Assumes: Default settings at reset except P_DSN
// Notes: Requests come from the root complex model
`timescale 1ns/10ps
`default_nettype none
`define C(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: %h %h", $time, a, e); end end
module pcfg_top_bench;
    localparam logic [63:0] DSN = 64'h0f1e2d3c4b5a6978;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, cfg_cpl_valid, usr_req_valid, usr_req_wr, cap_conflict;
    logic cfg_req_valid, cfg_req_wr;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0, retry_buf_size;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [5:0] link_width_adv;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [9:0] usr_req_dw, cfg_req_dw;
    logic [31:0] s_axi_wdata = 0, aer_unc_status = 32'h5a01, aer_cor_status = 32'h3c;
    logic [31:0] s_axi_rdata, cfg_cpl_data, usr_req_wdata, cfg_req_wdata;
    int miscompares = 0, checked = 0, cycles = 0;
    pcfg_top #(.P_DSN(DSN)) DUT (.*);
    pcfg_rc_model rc (.*);
    task automatic test_done();
        if (miscompares == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1;
        @(posedge aclk);
        s_axi_bready <= 0;
        `C(s_axi_bresp, r)
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1;
        @(posedge aclk);
        s_axi_rready <= 0;
        `C({s_axi_rresp, s_axi_rdata}, {r, e})
    endtask
    task automatic cf(input logic [9:0] dw, input logic [1:0] k, input logic [31:0] e);
        rc.issue(dw, k[1]);
        @(posedge aclk);
        `C({cfg_cpl_valid, usr_req_valid}, {k[0], !k[0]})
        if (k[0]) `C(cfg_cpl_data, e)
        else `C({usr_req_dw, usr_req_wr, usr_req_wdata}, {dw, k[1], 22'h0, dw})
    endtask
    task automatic t_reset();
        rd(8'h04, 0, 2'h0);
        `C(retry_buf_size, 3'h2)
        `C(link_width_adv, 6'h01)
        `C(cap_conflict, 1'b0)
        rd(8'h20, 0, 2'h2);
        wr(8'h20, 1, 2'h2);
    endtask
    task automatic t_core();
        cf(10'h018, 2'h1, 32'h00020010);
        cf(10'h01a, 2'h1, 32'h10);
        cf(10'h040, 2'h1, 32'h10c10003);
        cf(10'h041, 2'h1, DSN[31:0]);
        cf(10'h042, 2'h1, DSN[63:32]);
        cf(10'h043, 2'h1, 32'h00010001);
        cf(10'h044, 2'h1, aer_unc_status);
        cf(10'h047, 2'h1, aer_cor_status);
        cf(10'h200, 2'h3, 0);
    endtask
    task automatic t_user();
        wr(8'h00, 32'h9c, 2'h0);
        `C(retry_buf_size, 3'h5)
        `C(link_width_adv, 6'h04)
        wr(8'h10, 32'hff, 2'h0);
        cf(10'h018, 2'h1, 32'h00010010);
        cf(10'h01a, 2'h1, 0);
        cf(10'h01b, 2'h1, 32'h41);
        cf(10'h043, 2'h0, 0);
        cf(10'h200, 2'h2, 0);
        wr(8'h08, 32'h01abcdef, 2'h0);
        cf(10'h019, 2'h1, {4'h0, 25'h1abcdef, 3'h5});
        wr(8'h0c, 32'h15, 2'h0);
        cf(10'h021, 2'h1, 32'h15);
        wr(8'h04, 32'h40, 2'h0);
        rd(8'h04, 32'h40, 2'h0);
        wr(8'h00, 32'h85, 2'h0);
        `C(retry_buf_size, 3'h2)
        `C(cap_conflict, 1'b1)
        cf(10'h200, 2'h1, 0);
    endtask
    initial forever #2 aclk = ~aclk;
    always @(posedge aclk) if (++cycles == 3000) begin
        miscompares++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_reset();
        t_core();
        t_user();
        test_done();
    end
endmodule
`default_nettype wire
